// ### design/cpad_pkg.sv
// Purpose: Constants and carrier types for the processor-to-PCI address decoder.
// Assumes: 40-bit processor physical address, 32-bit PCI address, 4 byte enables.
// Notes:   Region bases are compared on address bits 39:28 (or finer where needed).
package cpad_pkg;

    localparam int unsigned CPU_AW       = 40;
    localparam int unsigned PCI_AW       = 32;
    localparam int unsigned UNCACHED_BIT = 39;

    // Decode keys taken from address bits 39:28
    localparam logic [11:0] KEY_MEM_LIMIT  = 12'h020;  // below 02.0 is main memory
    localparam logic [11:0] KEY_SPM0_LO    = 12'h800;
    localparam logic [11:0] KEY_SPM0_HI    = 12'h83f;
    localparam logic [11:0] KEY_SPM1_LO    = 12'h840;
    localparam logic [11:0] KEY_SPM1_HI    = 12'h84f;
    localparam logic [11:0] KEY_SPM2_LO    = 12'h850;
    localparam logic [11:0] KEY_SPM2_HI    = 12'h857;
    localparam logic [11:0] KEY_SPIOA_LO   = 12'h858;
    localparam logic [11:0] KEY_SPIOA_HI   = 12'h85b;
    localparam logic [11:0] KEY_SPIOB_LO   = 12'h85c;
    localparam logic [11:0] KEY_SPIOB_HI   = 12'h85f;
    localparam logic [11:0] KEY_DENSE_LO   = 12'h860;
    localparam logic [11:0] KEY_DENSE_HI   = 12'h86f;
    localparam logic [11:0] KEY_CFG_LO     = 12'h870;
    localparam logic [11:0] KEY_CFG_HI     = 12'h871;
    localparam logic [11:0] KEY_SPEC_LO    = 12'h872;
    localparam logic [11:0] KEY_SPEC_HI    = 12'h873;
    localparam logic [11:0] KEY_MAINREG    = 12'h874;
    localparam logic [11:0] KEY_MEMCREG    = 12'h875;
    localparam logic [11:0] KEY_XLATREG    = 12'h876;
    localparam logic [11:0] KEY_RESV       = 12'h877;
    localparam logic [11:0] KEY_FLASH_LO   = 12'h878;
    localparam logic [11:0] KEY_FLASH_HI   = 12'h87f;

    localparam int unsigned CACHE_BLOCK_BYTES = 64;
    localparam int unsigned BLOCK_LSB         = 6;     // log2 of the block size
    localparam int unsigned DENSE_MAX_BYTES   = 32;
    localparam logic [3:0]  DENSE_MAX_BURST   = 4'h8;  // longwords
    localparam int unsigned WBUF_COUNT        = 4;

    // Sparse size codes on processor address bits 4:3
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_TRI  = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;

    localparam logic [3:0] LWV_QUAD = 4'hc;

    typedef enum logic [3:0] {
        CPAD_R_NONE    = 4'h0,
        CPAD_R_MEM     = 4'h1,
        CPAD_R_SPM0    = 4'h2,
        CPAD_R_SPM1    = 4'h3,
        CPAD_R_SPM2    = 4'h4,
        CPAD_R_SPIOA   = 4'h5,
        CPAD_R_SPIOB   = 4'h6,
        CPAD_R_DENSE   = 4'h7,
        CPAD_R_CFG     = 4'h8,
        CPAD_R_SPEC    = 4'h9,
        CPAD_R_MAINREG = 4'ha,
        CPAD_R_MEMCREG = 4'hb,
        CPAD_R_XLATREG = 4'hc,
        CPAD_R_FLASH   = 4'hd
    } cpad_region_t;

    typedef enum logic [1:0] {
        CPAD_ST_IDLE  = 2'h0,
        CPAD_ST_BEAT2 = 2'h1
    } cpad_state_t;

    // Processor-side request
    typedef struct packed {
        logic [39:0] addr;
        logic        write;
        logic [3:0]  lw_valid;   // longword_valid_lines, one per longword of the octaword
        logic [7:0]  dense_lw;   // valid longwords of a dense write, up to 8
    } cpad_req_t;

    // Translated PCI-side command
    typedef struct packed {
        cpad_region_t region;
        logic         write;
        logic         pci_cycle;  // zero: complete locally, no PCI cycle
        logic         cacheable;
        logic [31:0]  pci_addr;
        logic [3:0]   byte_en_n;  // low marks a meaningful lane
        logic [3:0]   burst_len;  // longwords
        logic [31:0]  hole_mask;  // dense write byte enables, low = valid, 4 per longword
        logic         flush_req;  // always zero; DMA coherency flushes go out on flush_valid_o
    } cpad_cmd_t;

endpackage : cpad_pkg

// ### design/cpad_decoder.sv
// Purpose: Classifies processor physical addresses and builds PCI address, byte enables and burst length.
// Assumes: One request per accepted handshake; extension registers held stable by the caller.
// Notes:   A two-entry skid buffer sits on the command output so a stall by the PCI side loses nothing.
`timescale 1ns/10ps

// Operation
// - Address bit 39 clear selects cached memory, set selects uncached spaces.
// - Addresses 00.0000.0000 to 01.FFFF.FFFF decode as 8 GB cacheable main memory.
// - Cacheable transfers use fixed 64-byte blocks aligned to the block boundary.
// - DMA hits on cacheable memory raise cache read and flush requests; here only the flush is raised, on flush_valid_o.
// - 80.0 to 83.F decodes as sparse PCI memory region 0, 512 MB.
// - 84.0 to 84.F decodes as sparse PCI memory region 1, 128 MB.
// - 85.0 to 85.7 decodes as sparse PCI memory region 2, 64 MB.
// - 85.8 to 85.B is sparse I/O region A; 85.C to 85.F region B.
// - 86.x maps one-to-one onto 4 GB dense PCI memory; never I/O.
// - 87.0-87.1 is configuration space; 87.2-87.3 is special and interrupt acknowledge.
// - 87.4, 87.5, 87.6 are register ranges; 87.7 reserved; 87.8-87.F flash.
// - Dense: processor bits 31:3 pass unchanged to PCI bits 31:3.
// - Dense reads force PCI bit 2 to zero; writes copy processor bit 2.
// - Dense reads fetch at least a quadword, bursting two or more longwords.
// - Dense transfers are at most 32 bytes, a burst of up to 8 longwords.
// - Dense writes allow any longword pattern, holes marked by byte enables.
// - Four 32-byte write buffers drain to PCI in strict arrival order; here the two-entry skid buffer holds at most two writes.
// - Sparse reads never prefetch beyond bytes encoded in the address.
// - Sparse: bits 7:3 give length, enables, PCI 2:0; bits 30:8 give PCI 25:3 in memory regions, bits 29:8 give PCI 24:3 in I/O regions.
// - Sparse PCI bits 31:26 come from extension register or processor address; I/O region A drives them zero.
// - High sparse bits per region: region 0, 1, 2 mixes as specified.
// - Sparse memory PCI bits 1:0 are zero; byte enable zero marks valid lane.
// - Sparse writes derive address bits 4:3 from longword valid lines and cycle.
// - Undefined sparse encodings complete without error, data unspecified.
// - Sparse transfers never burst, except quadword writes as two longwords.
module cpad_decoder
    import cpad_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire cpad_req_t   req_i,
    input  wire logic        req_valid_i,
    input  wire logic        req_second_i,
    input  wire logic        dma_valid_i,
    input  wire logic [39:0] dma_addr_i,
    input  wire logic [31:0] sparse_mem_high_addr_ext_i,
    input  wire logic [31:0] sparse_io_high_addr_ext_i,
    input  wire logic        cmd_ready_i,
    output logic             req_ready_o,
    output cpad_cmd_t        cmd_o,
    output logic             cmd_valid_o,
    output logic             flush_valid_o,
    output logic [39:0]      flush_addr_o,
    output logic [2:0]       wbuf_used_o
);

    typedef struct packed {
        cpad_cmd_t        buf0;
        cpad_cmd_t        buf1;
        logic [1:0]       count;
        logic [2:0]       wbuf_used;
        logic             flush_valid;
        logic [39:0]      flush_addr;
        cpad_state_t      state;
        cpad_cmd_t        beat2;
        logic             req_ready;
        logic             cmd_valid;
    } cpad_state_s_t;

    cpad_state_s_t st_ff;
    cpad_state_s_t nxt_st;

    function automatic cpad_region_t decode_region(input logic [39:0] a);
        logic [11:0] k;
        k = a[39:28];
        if (!a[UNCACHED_BIT]) begin
            decode_region = (k < KEY_MEM_LIMIT) ? CPAD_R_MEM : CPAD_R_NONE;
        end else if (k >= KEY_SPM0_LO && k <= KEY_SPM0_HI) begin
            decode_region = CPAD_R_SPM0;
        end else if (k >= KEY_SPM1_LO && k <= KEY_SPM1_HI) begin
            decode_region = CPAD_R_SPM1;
        end else if (k >= KEY_SPM2_LO && k <= KEY_SPM2_HI) begin
            decode_region = CPAD_R_SPM2;
        end else if (k >= KEY_SPIOA_LO && k <= KEY_SPIOA_HI) begin
            decode_region = CPAD_R_SPIOA;
        end else if (k >= KEY_SPIOB_LO && k <= KEY_SPIOB_HI) begin
            decode_region = CPAD_R_SPIOB;
        end else if (k >= KEY_DENSE_LO && k <= KEY_DENSE_HI) begin
            decode_region = CPAD_R_DENSE;
        end else if (k >= KEY_CFG_LO && k <= KEY_CFG_HI) begin
            decode_region = CPAD_R_CFG;
        end else if (k >= KEY_SPEC_LO && k <= KEY_SPEC_HI) begin
            decode_region = CPAD_R_SPEC;
        end else if (k == KEY_MAINREG) begin
            decode_region = CPAD_R_MAINREG;
        end else if (k == KEY_MEMCREG) begin
            decode_region = CPAD_R_MEMCREG;
        end else if (k == KEY_XLATREG) begin
            decode_region = CPAD_R_XLATREG;
        end else if (k >= KEY_FLASH_LO && k <= KEY_FLASH_HI) begin
            decode_region = CPAD_R_FLASH;
        end else begin
            decode_region = CPAD_R_NONE;
        end
    endfunction : decode_region

    // Sparse byte enables from size code and offset; undefined codes fall through to a
    // harmless pattern so the cycle still completes.
    function automatic logic [3:0] sparse_be_n(input logic [1:0] sz, input logic [1:0] ofs);
        sparse_be_n = 4'hf;
        case (sz)
            SZ_BYTE: sparse_be_n = ~(4'h1 << ofs);
            SZ_WORD: sparse_be_n = (ofs == 2'h3) ? 4'hf : ~(4'h3 << ofs);
            SZ_TRI:  sparse_be_n = (ofs[1]) ? 4'hf : ~(4'h7 << ofs);
            default: sparse_be_n = 4'h0;
        endcase
    endfunction : sparse_be_n

    // Write beat 4:3 from longword valid lines and data cycle
    function automatic logic [1:0] sparse_wr_a43(input logic [3:0] lwv, input logic second);
        sparse_wr_a43 = 2'h0;
        if (lwv == LWV_QUAD) begin
            sparse_wr_a43 = 2'h3;
        end else if (lwv[3] || lwv[2]) begin
            sparse_wr_a43 = {second, 1'b1};
        end else begin
            sparse_wr_a43 = {second, 1'b0};
        end
    endfunction : sparse_wr_a43

    cpad_cmd_t   c;
    logic        take;
    logic        push;
    logic        pop;
    logic        pop_wr;
    logic        is_sparse;
    logic        is_quad;
    logic [1:0]  a43;
    logic [3:0]  dense_cnt;

    always_comb begin
        c          = '0;
        is_sparse  = 1'b0;
        is_quad    = 1'b0;
        a43        = 2'h0;
        dense_cnt  = 4'h0;
        c.region   = decode_region(req_i.addr);
        c.write    = req_i.write;
        c.pci_cycle = 1'b1;
        c.byte_en_n = 4'h0;
        c.burst_len = 4'h1;
        c.hole_mask = '0;
        a43 = req_i.write ? sparse_wr_a43(req_i.lw_valid, req_second_i) : req_i.addr[4:3];
        is_quad = (a43 == 2'h3) && (req_i.addr[6:5] == 2'h3);
        case (c.region)
            CPAD_R_MEM: begin
                c.cacheable = 1'b1;
                c.pci_cycle = 1'b0;
                c.pci_addr  = {req_i.addr[31:BLOCK_LSB], 6'h00};
            end
            CPAD_R_DENSE: begin
                c.pci_addr = {req_i.addr[31:3], (req_i.write ? req_i.addr[2] : 1'b0), 2'h0};
                for (int i = 0; i < 8; i++) begin
                    dense_cnt = dense_cnt + {3'h0, req_i.dense_lw[i]};
                    c.hole_mask[i*4 +: 4] = req_i.dense_lw[i] ? 4'h0 : 4'hf;
                end
                if (req_i.write) begin
                    c.burst_len = (dense_cnt == 4'h0) ? 4'h1 : DENSE_MAX_BURST - {1'b0, req_i.addr[4:2]};
                end else begin
                    c.burst_len = (dense_cnt < 4'h2) ? 4'h2 : dense_cnt;
                end
            end
            CPAD_R_SPM0, CPAD_R_SPM1, CPAD_R_SPM2, CPAD_R_SPIOA, CPAD_R_SPIOB: begin
                is_sparse = 1'b1;
            end
            CPAD_R_CFG, CPAD_R_SPEC: begin
                c.pci_addr = {3'h0, req_i.addr[28:0]};
            end
            CPAD_R_NONE: begin
                c.pci_cycle = 1'b0;
            end
            default: begin
                c.pci_cycle = 1'b0;
                c.pci_addr  = {4'h0, req_i.addr[27:0]};
            end
        endcase
        if (is_sparse) begin
            c.byte_en_n = is_quad ? 4'h0 : sparse_be_n(a43, req_i.addr[6:5]);
            c.burst_len = (is_quad && req_i.write) ? 4'h2 : 4'h1;
            c.pci_addr[24:3] = req_i.addr[29:8];
            c.pci_addr[2:0]  = is_quad ? 3'h0 : {req_i.addr[7], 2'h0};
            case (c.region)
                CPAD_R_SPM0: c.pci_addr[31:25] = {sparse_mem_high_addr_ext_i[31:29],
                                                 req_i.addr[33:31], req_i.addr[30]};
                CPAD_R_SPM1: c.pci_addr[31:25] = {sparse_mem_high_addr_ext_i[15:11],
                                                 req_i.addr[31:30]};
                CPAD_R_SPM2: c.pci_addr[31:25] = {sparse_mem_high_addr_ext_i[7:2], req_i.addr[30]};
                CPAD_R_SPIOA: begin
                    c.pci_addr[31:25] = 7'h00;
                    c.pci_addr[2:0]   = is_quad ? 3'h0 : {req_i.addr[7], req_i.addr[6:5]};
                end
                default: begin
                    c.pci_addr[31:25] = sparse_io_high_addr_ext_i[31:25];
                    c.pci_addr[2:0]   = is_quad ? 3'h0 : {req_i.addr[7], req_i.addr[6:5]};
                end
            endcase
        end
    end

    // Write buffers are modelled as an in-order occupancy count; the skid
    // buffer itself is the FIFO, so no write can overtake an earlier one.
    assign take = req_valid_i && (st_ff.count < 2'h2) && (st_ff.state == CPAD_ST_IDLE)
                  && (!req_i.write || st_ff.wbuf_used < 3'(WBUF_COUNT));
    assign pop  = (st_ff.count != 2'h0) && cmd_ready_i;
    // A quadword's second beat and local writes never took a slot, so they free none
    assign pop_wr = pop && st_ff.buf0.write && st_ff.buf0.pci_cycle && (st_ff.buf0.burst_len != 4'h0);

    always_comb begin
        nxt_st = st_ff;
        push   = take || (st_ff.state == CPAD_ST_BEAT2 && st_ff.count < 2'h2);
        if (pop) begin
            nxt_st.buf0 = st_ff.buf1;
        end
        if (push) begin
            if ((st_ff.count == 2'h0) || (st_ff.count == 2'h1 && pop)) begin
                nxt_st.buf0 = (st_ff.state == CPAD_ST_BEAT2) ? st_ff.beat2 : c;
            end else begin
                nxt_st.buf1 = (st_ff.state == CPAD_ST_BEAT2) ? st_ff.beat2 : c;
            end
        end
        nxt_st.count = st_ff.count + 2'(push) - 2'(pop);
        if (take && c.write && c.pci_cycle && !(st_ff.wbuf_used != 3'h0 && pop_wr)) begin
            nxt_st.wbuf_used = st_ff.wbuf_used + 3'h1;
        end else if (!(take && c.write && c.pci_cycle) && pop_wr && st_ff.wbuf_used != 3'h0) begin
            nxt_st.wbuf_used = st_ff.wbuf_used - 3'h1;
        end
        case (st_ff.state)
            CPAD_ST_IDLE: begin
                if (take && is_sparse && is_quad && req_i.write) begin
                    nxt_st.state = CPAD_ST_BEAT2;
                    nxt_st.beat2 = c;
                    nxt_st.beat2.pci_addr = c.pci_addr + 32'h4;
                    nxt_st.beat2.burst_len = 4'h0;
                end
            end
            CPAD_ST_BEAT2: begin
                if (push) begin
                    nxt_st.state = CPAD_ST_IDLE;
                end
            end
            default: nxt_st.state = CPAD_ST_IDLE;
        endcase
        nxt_st.flush_valid = dma_valid_i && (decode_region(dma_addr_i) == CPAD_R_MEM);
        nxt_st.flush_addr  = {dma_addr_i[39:BLOCK_LSB], 6'h00};
        // Ready and valid ride in the state so both outputs come from flops
        nxt_st.cmd_valid   = (nxt_st.count != 2'h0);
        nxt_st.req_ready   = (nxt_st.count < 2'h2) && (nxt_st.state == CPAD_ST_IDLE)
                             && (nxt_st.wbuf_used < 3'(WBUF_COUNT));
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign req_ready_o   = st_ff.req_ready;
    assign cmd_o         = st_ff.buf0;
    assign cmd_valid_o   = st_ff.cmd_valid;
    assign flush_valid_o = st_ff.flush_valid;
    assign flush_addr_o  = st_ff.flush_addr;
    assign wbuf_used_o   = st_ff.wbuf_used;

endmodule : cpad_decoder

// ### tb/cpad_decoder_sva.sv
// Purpose: Port-level assertions for cpad_decoder.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Bound to every decoder instance.
`timescale 1ns/10ps
module cpad_decoder_sva
    import cpad_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire cpad_req_t   req_i,
    input wire logic        req_valid_i,
    input wire logic        req_second_i,
    input wire logic        dma_valid_i,
    input wire logic [39:0] dma_addr_i,
    input wire logic [31:0] sparse_mem_high_addr_ext_i,
    input wire logic [31:0] sparse_io_high_addr_ext_i,
    input wire logic        cmd_ready_i,
    input wire logic        req_ready_o,
    input wire cpad_cmd_t   cmd_o,
    input wire logic        cmd_valid_o,
    input wire logic        flush_valid_o,
    input wire logic [39:0] flush_addr_o,
    input wire logic [2:0]  wbuf_used_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    flush_dma_a: assert property (dma_valid_i && dma_addr_i[39:33] == 7'h00 |=> flush_valid_o
        && flush_addr_o == {$past(dma_addr_i[39:6]), 6'h00}) else $error("flush missing or misaligned");
    flush_cause_a: assert property (flush_valid_o |-> $past(dma_valid_i)) else $error("flush without dma");
    cmd_hold_a: assert property (cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_o))
        else $error("stalled command changed");
    dense_read_a: assert property (cmd_valid_o && cmd_o.region == CPAD_R_DENSE && !cmd_o.write
        |-> cmd_o.pci_addr[2] == 1'b0 && cmd_o.burst_len inside {[4'h2:4'h8]}) else $error("dense read shape");
    dense_write_a: assert property (cmd_valid_o && cmd_o.region == CPAD_R_DENSE && cmd_o.write
        |-> cmd_o.burst_len == 4'h8 - cmd_o.pci_addr[4:2]) else $error("dense write burst");
    sparse_low_a: assert property (cmd_valid_o && cmd_o.region inside {CPAD_R_SPM0, CPAD_R_SPM1, CPAD_R_SPM2}
        |-> cmd_o.pci_addr[1:0] == 2'h0 && cmd_o.burst_len <= 4'h2) else $error("sparse memory shape");
    local_only_a: assert property (cmd_valid_o && cmd_o.region inside {CPAD_R_NONE, CPAD_R_MEM,
        CPAD_R_MAINREG, CPAD_R_MEMCREG, CPAD_R_XLATREG, CPAD_R_FLASH} |-> !cmd_o.pci_cycle) else $error("pci cycle");
    cache_sel_a: assert property (cmd_valid_o |-> cmd_o.cacheable == (cmd_o.region == CPAD_R_MEM))
        else $error("cacheable flag wrong");
    wbuf_max_a: assert property (wbuf_used_o <= 3'h4) else $error("write buffer count over four");
    cover property (cmd_valid_o && !cmd_ready_i ##1 cmd_valid_o);
    cover property (flush_valid_o);
    cover property (cmd_valid_o && cmd_o.region == CPAD_R_DENSE && cmd_o.write);
endmodule : cpad_decoder_sva

bind cpad_decoder cpad_decoder_sva i_sva (.clk_i, .reset_i, .req_i, .req_valid_i, .req_second_i, .dma_valid_i,
    .dma_addr_i, .sparse_mem_high_addr_ext_i, .sparse_io_high_addr_ext_i, .cmd_ready_i, .req_ready_o, .cmd_o,
    .cmd_valid_o, .flush_valid_o, .flush_addr_o, .wbuf_used_o);

// ### tb/cpad_pci_sink.sv
// Purpose: PCI-side consumer model that collects translated commands.
// Assumes: Commands pop on a rising edge with valid and ready high.
// Notes:   Stall knob lets tests back up the skid buffer.
`timescale 1ns/10ps
module cpad_pci_sink
    import cpad_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      reset_i,
    input  wire logic      stall_i,
    input  wire cpad_cmd_t cmd_i,
    input  wire logic      cmd_valid_i,
    output logic           cmd_ready_o
);
    cpad_cmd_t got_q[$];
    // Ready held low in reset so nothing is counted as popped before the bridge runs
    assign cmd_ready_o = !stall_i && !reset_i;
    always @(posedge clk_i) begin
        if (!reset_i && cmd_valid_i && cmd_ready_o) begin
            got_q.push_back(cmd_i);
        end
    end
endmodule : cpad_pci_sink

// ### tb/cpad_decoder_tb_top.sv
// Purpose: Self-checking bench for the address decoder.
// Assumes: Requests are presented one at a time and taken when req_ready_o is high.
// Notes:   Expected PCI addresses are rebuilt from the region rules.
`timescale 1ns/10ps
module cpad_decoder_tb_top
    import cpad_pkg::*;
;
    logic         clk_i = 1'b0;
    logic         reset_i = 1'b1;
    cpad_req_t    req_i = '0;
    logic         req_valid_i = 1'b0;
    logic         req_second_i = 1'b0;
    logic         dma_valid_i = 1'b0;
    logic [39:0]  dma_addr_i = '0;
    logic [31:0]  mem_ext = 32'ha000_d8b4;
    logic [31:0]  io_ext = 32'h5a00_0000;
    logic         stall = 1'b0;
    logic         cmd_ready, req_ready_o, cmd_valid_o, flush_valid_o;
    cpad_cmd_t    cmd_o;
    logic [39:0]  flush_addr_o;
    logic [2:0]   wbuf_used_o;
    int           mismatches = 0;
    int           n_checks = 0;
    // One nibble per {size, offset} code; undefined word and tri-byte codes expect all lanes off,
    // undefined longword offsets all lanes on
    logic [63:0]  be_tab = 64'h0000_ff18_f39c_7bde;
    logic [39:0]  ra [20] = '{40'h01_ffff_ffc0, 40'h02_0000_0000, 40'h80_0000_0000, 40'h83_ffff_ffe0,
        40'h84_ffff_ffe0, 40'h85_7fff_ffe0, 40'h85_8000_0000, 40'h85_bfff_ffe0, 40'h85_c000_0000, 40'h86_0000_0000,
        40'h86_ffff_ffe0, 40'h87_0000_0000, 40'h87_1fff_ffe0, 40'h87_2000_0000, 40'h87_3fff_ffe0, 40'h87_4000_0000,
        40'h87_5000_0000, 40'h87_6000_0000, 40'h87_7000_0000, 40'h87_ffff_ffe0};
    cpad_region_t rr [20] = '{CPAD_R_MEM, CPAD_R_NONE, CPAD_R_SPM0, CPAD_R_SPM0, CPAD_R_SPM1, CPAD_R_SPM2,
        CPAD_R_SPIOA, CPAD_R_SPIOA, CPAD_R_SPIOB, CPAD_R_DENSE, CPAD_R_DENSE, CPAD_R_CFG, CPAD_R_CFG, CPAD_R_SPEC,
        CPAD_R_SPEC, CPAD_R_MAINREG, CPAD_R_MEMCREG, CPAD_R_XLATREG, CPAD_R_NONE, CPAD_R_FLASH};

    always #5 clk_i = ~clk_i;

    cpad_decoder i_dut (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .req_valid_i(req_valid_i),
        .req_second_i(req_second_i), .dma_valid_i(dma_valid_i), .dma_addr_i(dma_addr_i),
        .sparse_mem_high_addr_ext_i(mem_ext), .sparse_io_high_addr_ext_i(io_ext), .cmd_ready_i(cmd_ready),
        .req_ready_o(req_ready_o), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .flush_valid_o(flush_valid_o),
        .flush_addr_o(flush_addr_o), .wbuf_used_o(wbuf_used_o));
    cpad_pci_sink i_sink (.clk_i(clk_i), .reset_i(reset_i), .stall_i(stall), .cmd_i(cmd_o),
        .cmd_valid_i(cmd_valid_o), .cmd_ready_o(cmd_ready));

    function automatic logic [31:0] sp_addr(input logic [39:0] a);
        logic [5:0] hi;
        if (!a[34]) hi = {mem_ext[31:29], a[33:31]};
        else if (!a[32]) hi = {mem_ext[15:11], a[31]};
        else hi = mem_ext[7:2];
        return {hi, a[30:8], a[7], 2'h0};
    endfunction : sp_addr

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [40:0] e, input logic [40:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Holds the request until an edge at which the decoder reports room to take it
    task automatic send(input logic [39:0] a, input logic w, input logic [3:0] lv, input logic [7:0] dl,
                        input logic sec);
        int n;
        n = 0;
        @(posedge clk_i);
        #1;
        req_i = '{addr: a, write: w, lw_valid: lv, dense_lw: dl};
        req_second_i = sec;
        req_valid_i = 1'b1;
        while (req_ready_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b0;
        chk("take", 1, n < 50);
    endtask : send

    task automatic get(output cpad_cmd_t c);
        int n;
        n = 0;
        while (i_sink.got_q.size() == 0 && n < 100) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("arrival", 1, n < 100);
        c = (n < 100) ? i_sink.got_q.pop_front() : 'x;
    endtask : get

    task automatic t_decode();
        cpad_cmd_t c;
        for (int i = 0; i < 20; i++) begin
            send(ra[i], 1'b0, 4'h1, 8'h01, 1'b0);
            get(c);
            chk("region", rr[i], c.region);
            chk("pci_cycle", rr[i] >= CPAD_R_SPM0 && rr[i] <= CPAD_R_SPEC, c.pci_cycle);
            if (rr[i] == CPAD_R_SPIOB) chk("io_addr", {io_ext[31:25], ra[i][29:5]}, c.pci_addr);
        end
        $display("test decode done");
    endtask : t_decode

    task automatic t_sparse();
        cpad_cmd_t c;
        logic [39:0] a;
        for (int k = 0; k < 18; k++) begin
            a = (k < 16) ? {40'h82_8765_4300 | {33'h0, k[1:0], k[3:2], 3'h0}} : (k == 16 ? 40'h84_9abc_de80
                : 40'h85_3456_7880);
            send(a, 1'b0, 4'h1, 8'h00, 1'b0);
            get(c);
            chk("sp_addr", sp_addr(a), c.pci_addr);
            if (k < 16) chk("sp_be", be_tab[4*k +: 4], c.byte_en_n);
            if (k < 15) chk("sp_burst", 4'h1, c.burst_len);
        end
        $display("test sparse read done");
    endtask : t_sparse

    task automatic t_sparse_write();
        cpad_cmd_t c;
        logic [3:0] lv [3] = '{4'h4, 4'h8, 4'h1};
        logic [3:0] be [3] = '{4'hc, 4'h0, 4'he};
        for (int i = 0; i < 3; i++) begin
            send(40'h81_2345_6710, 1'b1, lv[i], 8'h00, i == 1);
            get(c);
            chk("sw_be", be[i], c.byte_en_n);
            chk("sw_addr", sp_addr(40'h81_2345_6710), c.pci_addr);
        end
        send(40'h81_2345_6778, 1'b1, LWV_QUAD, 8'h00, 1'b1);
        get(c);
        chk("qw_first", {sp_addr(40'h81_2345_6778), 4'h2}, {c.pci_addr, c.burst_len});
        get(c);
        chk("qw_second", {sp_addr(40'h81_2345_6778) + 32'h4, 4'h0}, {c.pci_addr, c.burst_len});
        $display("test sparse write done");
    endtask : t_sparse_write

    task automatic t_dense();
        cpad_cmd_t c;
        send(40'h86_1234_5674, 1'b0, 4'h1, 8'h20, 1'b0);
        get(c);
        chk("dr_addr", 32'h1234_5670, c.pci_addr);
        chk("dr_burst", 1, c.burst_len >= 4'h2);
        send(40'h86_1234_5674, 1'b1, 4'h1, 8'ha0, 1'b0);
        get(c);
        chk("dw_addr", {32'h1234_5674, 4'h3}, {c.pci_addr, c.burst_len});
        chk("dw_holes", 32'h0f0f_ffff, c.hole_mask);
        send(40'h86_0000_0000, 1'b1, 4'h1, 8'hff, 1'b0);
        get(c);
        chk("dw_max", 4'h8, c.burst_len);
        $display("test dense done");
    endtask : t_dense

    task automatic t_stall();
        cpad_cmd_t c;
        stall = 1'b1;
        send(40'h86_0000_0100, 1'b1, 4'h1, 8'hff, 1'b0);
        send(40'h86_0000_0200, 1'b1, 4'h1, 8'hff, 1'b0);
        repeat (3) @(posedge clk_i);
        #1;
        chk("full", {1'b0, 1'b1, 3'h2}, {req_ready_o, cmd_valid_o, wbuf_used_o});
        chk("head", 32'h0000_0100, cmd_o.pci_addr);
        stall = 1'b0;
        get(c);
        chk("order0", 32'h0000_0100, c.pci_addr);
        get(c);
        chk("order1", 32'h0000_0200, c.pci_addr);
        @(posedge clk_i);
        #1;
        chk("drained", 3'h0, wbuf_used_o);
        $display("test stall done");
    endtask : t_stall

    task automatic t_dma();
        logic [39:0] da [3] = '{40'h00_0000_0123, 40'h01_ffff_ffff, 40'h86_0000_0040};
        logic [40:0] ex [3] = '{{1'b1, 40'h00_0000_0100}, {1'b1, 40'h01_ffff_ffc0}, {1'b0, 40'h0}};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            #1;
            dma_valid_i = 1'b1;
            dma_addr_i = da[i];
            @(posedge clk_i);
            #1;
            dma_valid_i = 1'b0;
            chk("flush", ex[i], {flush_valid_o, ex[i][40] ? flush_addr_o : 40'h0});
            @(posedge clk_i);
            #1;
            chk("flush_pulse", 1'b0, flush_valid_o);
        end
        $display("test dma done");
    endtask : t_dma

    initial begin
        repeat (8) @(posedge clk_i);
        #1;
        chk("in_reset", 2'h0, {cmd_valid_o, req_ready_o});
        repeat (8) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("ready_after_reset", 1'b1, req_ready_o);
        t_decode();
        t_sparse();
        t_sparse_write();
        t_dense();
        t_stall();
        t_dma();
        end_sim();
    end

    initial begin
        #300000;
        mismatches++;
        end_sim();
    end
endmodule : cpad_decoder_tb_top
